/* tdho_top.sv */
// data-link transmit controller with option register, fifo and bus slave
// Function
// - idle fill with message select aborts a frame in progress with fe, then sends only flags 7e, holding back frames; one in its check octets completes
// - with no frame waiting the line carries repeated flag octets
// - idle fill bit has no effect while bit-pattern signalling is selected
// - check-append set adds crc octets after each message frame, else none
// - check-append bit has no effect in bit-pattern signalling
// - select 0 sends bit patterns, 1 sends message frames; resets to 0
// - bit pattern repeats count times then signals done; zero repeats forever
// - message count is frame octets including header, excluding check octets
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module tdho_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // handshakes and pointer steps
    always_comb
    begin
        push   = in_valid_i && in_ready_o;
        pop    = out_valid_o && out_ready_i;
        wp_nxt = push ? PW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? PW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop)
            cnt_nxt = (PW+1)'(cnt_r + 1'b1);
        else if (pop && !push)
            cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end

    assign in_ready_o  = (cnt_r != (PW+1)'(D));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];

    // pointer and storage registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push)
            mem_r[wp_r] <= in_data_i;
    end
endmodule : tdho_fifo

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module tdho_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire tdho_pkg::tdho_wb_req_t wb_i,
    output logic [tdho_pkg::WB_DW-1:0] wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  dl_slot_i,
    output logic                       tx_bit_o,
    output logic                       transmit_transfer_done_o
);
    import tdho_pkg::*;

    tdho_ctrl_t          ctl_r, ctl_nxt;
    logic [CNT_W-1:0]    cnt_r, cnt_nxt;
    logic                ack_r, ack_nxt, go_r, go_nxt, stop_r, stop_nxt;
    logic                done_r, done_nxt, under_r, under_nxt;
    logic [WB_DW-1:0]    rd_r, rd_nxt;
    logic                req, wr_fire, wr_lo, push;
    logic                f_ready, f_valid, f_pop;
    logic [FIFO_W-1:0]   f_data;
    tdho_tx_state_t      st_r, st_nxt;
    logic [15:0]         sh_r, sh_nxt, crc_r, crc_nxt;
    logic [4:0]          nb_r, nb_nxt;
    logic [2:0]          ones_r, ones_nxt;
    logic                stf_r, stf_nxt, fcs_r, fcs_nxt;
    logic                bit_r, bit_nxt, pulse_r, pulse_nxt;
    logic [CNT_W-1:0]    left_r, left_nxt;
    logic [7:0]          pat_r, pat_nxt;
    logic                load, idle_eff, data_bit, done_ev, under_ev;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign req     = wb_i.cyc && wb_i.stb;
    assign wr_fire = req && ack_r && wb_i.we;
    assign wr_lo   = wr_fire && wb_i.sel[0];
    assign push    = wr_lo && (wb_i.adr == ADR_DATA);

    // ack waits on fifo space for octet pushes
    always_comb
    begin
        ack_nxt = req && !ack_r
                  && !(wb_i.we && wb_i.adr == ADR_DATA && !f_ready);
        rd_nxt  = '0;
        unique case (wb_i.adr)
            ADR_CTRL:   rd_nxt[2:0] = ctl_r;
            ADR_COUNT:  rd_nxt[CNT_W-1:0] = cnt_r;
            ADR_STATUS:
            begin
                rd_nxt[STA_BUSY]  = (st_r != TX_FLAG) || go_r;
                rd_nxt[STA_DONE]  = done_r;
                rd_nxt[STA_UNDER] = under_r;
                rd_nxt[STA_FULL]  = !f_ready;
                rd_nxt[STA_EMPTY] = !f_valid;
            end
            default:    rd_nxt = '0; // unmapped reads zero
        endcase
    end

    // software controls and sticky flags, set wins over clear
    always_comb
    begin
        ctl_nxt   = ctl_r;
        cnt_nxt   = cnt_r;
        go_nxt    = go_r;
        stop_nxt  = stop_r;
        if (wr_lo && wb_i.adr == ADR_CTRL)
            ctl_nxt = wb_i.dat[2:0];
        if (wr_lo && wb_i.adr == ADR_COUNT)
            cnt_nxt = wb_i.dat[CNT_W-1:0];
        if (load && st_r == TX_FLAG && go_r && f_valid && !idle_eff)
            go_nxt = 1'b0;
        if (load && st_r == TX_BOS)
            stop_nxt = 1'b0;
        if (wr_lo && wb_i.adr == ADR_CMD && wb_i.dat[CMD_GO])
            go_nxt = 1'b1;
        if (wr_lo && wb_i.adr == ADR_CMD && wb_i.dat[CMD_STOP])
            stop_nxt = 1'b1;
        done_nxt  = done_r;
        under_nxt = under_r;
        if (wr_lo && wb_i.adr == ADR_STATUS && wb_i.dat[STA_DONE])
            done_nxt = 1'b0;
        if (wr_lo && wb_i.adr == ADR_STATUS && wb_i.dat[STA_UNDER])
            under_nxt = 1'b0;
        if (done_ev)
            done_nxt = 1'b1;
        if (under_ev)
            under_nxt = 1'b1;
    end

    // bus and control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctl_r   <= CTRL_RESET;
            cnt_r   <= CNT_RESET;
            ack_r   <= 1'b0;
            rd_r    <= '0;
            go_r    <= 1'b0;
            stop_r  <= 1'b0;
            done_r  <= 1'b0;
            under_r <= 1'b0;
        end
        else
        begin
            ctl_r   <= ctl_nxt;
            cnt_r   <= cnt_nxt;
            ack_r   <= ack_nxt;
            rd_r    <= rd_nxt;
            go_r    <= go_nxt;
            stop_r  <= stop_nxt;
            done_r  <= done_nxt;
            under_r <= under_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    tdho_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (f_ready),
        .in_data_i   (wb_i.dat[FIFO_W-1:0]),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_data)
    );

    // ------------------------------------------------------------
    // serial transmitter
    // ------------------------------------------------------------
    assign idle_eff = ctl_r.idle_fill && ctl_r.signalling_select;
    assign data_bit = dl_slot_i && ones_r != ONES_MAX;
    assign load     = data_bit && nb_r == 5'h01;

    // bit emission, stuffing, crc and octet sequencing
    always_comb
    begin
        st_nxt = st_r; sh_nxt = sh_r; nb_nxt = nb_r;
        ones_nxt = ones_r; stf_nxt = stf_r; fcs_nxt = fcs_r;
        crc_nxt = crc_r; bit_nxt = bit_r; left_nxt = left_r;
        pat_nxt = pat_r; f_pop = 1'b0; done_ev = 1'b0; under_ev = 1'b0;
        if (dl_slot_i && ones_r == ONES_MAX)
        begin
            bit_nxt  = 1'b0; // stuffed zero after five ones
            ones_nxt = '0;
        end
        else if (dl_slot_i)
        begin
            bit_nxt  = sh_r[0];
            ones_nxt = (stf_r && sh_r[0]) ? 3'(ones_r + 1'b1) : '0;
            if (st_r == TX_DATA)
                crc_nxt = (crc_r >> 1)
                          ^ ((crc_r[0] ^ sh_r[0]) ? CRC_POLY : '0);
            sh_nxt = sh_r >> 1;
            nb_nxt = 5'(nb_r - 1'b1);
        end
        if (load)
        begin
            sh_nxt  = {8'h00, FLAG_OCTET};
            nb_nxt  = OCTET_BITS;
            stf_nxt = 1'b0;
            unique case (st_r)
                TX_FLAG:
                    if (go_r && f_valid && !ctl_r.signalling_select)
                    begin
                        st_nxt   = TX_BOS;
                        f_pop    = 1'b1;
                        pat_nxt  = f_data;
                        left_nxt = cnt_r;
                        sh_nxt   = {BOS_TAIL, f_data};
                        nb_nxt   = WORD_BITS;
                    end
                    else if (go_r && f_valid && !idle_eff && cnt_r != '0)
                    begin
                        st_nxt   = TX_DATA;
                        f_pop    = 1'b1;
                        fcs_nxt  = ctl_r.check_append;
                        crc_nxt  = CRC_INIT;
                        left_nxt = CNT_W'(cnt_r - 1'b1);
                        sh_nxt   = {8'h00, f_data};
                        stf_nxt  = 1'b1;
                    end
                TX_DATA:
                    if (idle_eff || (left_r != '0 && !f_valid))
                    begin
                        st_nxt   = TX_FLAG;
                        sh_nxt   = {8'h00, ABORT_OCTET};
                        under_ev = !idle_eff;
                    end
                    else if (left_r != '0)
                    begin
                        f_pop    = 1'b1;
                        left_nxt = CNT_W'(left_r - 1'b1);
                        sh_nxt   = {8'h00, f_data};
                        stf_nxt  = 1'b1;
                    end
                    else if (fcs_r)
                    begin
                        st_nxt  = TX_FCS;
                        sh_nxt  = ~crc_nxt;
                        nb_nxt  = WORD_BITS;
                        stf_nxt = 1'b1;
                    end
                    else
                    begin
                        st_nxt  = TX_FLAG;
                        done_ev = 1'b1;
                    end
                TX_FCS:
                begin
                    st_nxt  = TX_FLAG;
                    done_ev = 1'b1;
                end
                TX_BOS:
                    if ((cnt_r != '0 && left_r == 7'h01) || stop_r)
                    begin
                        st_nxt  = TX_FLAG;
                        done_ev = cnt_r != '0 && !stop_r;
                    end
                    else
                    begin
                        left_nxt = (left_r == '0) ? '0 : CNT_W'(left_r - 1'b1);
                        sh_nxt   = {BOS_TAIL, pat_r};
                        nb_nxt   = WORD_BITS;
                    end
            endcase
        end
        pulse_nxt = done_ev;
    end

    // transmitter registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= TX_FLAG; sh_r <= {8'h00, FLAG_OCTET};
            nb_r <= OCTET_BITS; ones_r <= '0; stf_r <= 1'b0;
            fcs_r <= 1'b0; crc_r <= CRC_INIT; bit_r <= 1'b1;
            left_r <= '0; pat_r <= '0; pulse_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt; sh_r <= sh_nxt;
            nb_r <= nb_nxt; ones_r <= ones_nxt; stf_r <= stf_nxt;
            fcs_r <= fcs_nxt; crc_r <= crc_nxt; bit_r <= bit_nxt;
            left_r <= left_nxt; pat_r <= pat_nxt; pulse_r <= pulse_nxt;
        end
    end

    assign tx_bit_o                 = bit_r;
    assign transmit_transfer_done_o = pulse_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_single_pulse_a: assert property (ack_r |=> !ack_r)
        else $error("ack held longer than one cycle");
    idle_flags_a: assert property (
        (load && st_r == TX_FLAG && idle_eff) |=>
            st_r == TX_FLAG && sh_r[7:0] == FLAG_OCTET)
        else $error("idle fill let a frame start");
    flag_fill_a: assert property (
        (load && st_r == TX_FLAG && !go_r) |=>
            st_r == TX_FLAG && sh_r[7:0] == FLAG_OCTET && nb_r == OCTET_BITS)
        else $error("no flag octet while idle");
    bos_ignores_idle_a: assert property (
        (load && st_r == TX_FLAG && go_r && f_valid
            && !ctl_r.signalling_select) |=> st_r == TX_BOS)
        else $error("bit pattern not started");
    check_append_a: assert property (
        (load && st_r == TX_DATA && left_r == '0 && !idle_eff) |=>
            (fcs_r ? st_r == TX_FCS : st_r == TX_FLAG))
        else $error("check octets wrongly appended");
    select_reset_a: assert property (
        $fell(rst_i) |-> !ctl_r.signalling_select)
        else $error("select not cleared by reset");
    bos_done_a: assert property (
        (load && st_r == TX_BOS && cnt_r != '0 && left_r == 7'h01
            && !stop_r) |=> transmit_transfer_done_o)
        else $error("done pulse missing after repeats");
    msg_count_a: assert property (
        (load && st_r == TX_DATA && left_r != '0 && f_valid && !idle_eff)
            |=> left_r == $past(left_r) - 7'h01)
        else $error("octet count not decremented");
    crc_seed_a: assert property (
        (st_r == TX_FLAG ##1 st_r == TX_DATA) |-> crc_r == CRC_INIT)
        else $error("crc not seeded at frame start");
    stuff_limit_a: assert property (ones_r <= ONES_MAX)
        else $error("six ones without a stuffed zero");

    frame_fcs_c: cover property (st_r == TX_FCS ##1 st_r == TX_FLAG);
    bos_done_c: cover property (transmit_transfer_done_o && st_r == TX_FLAG);
    abort_c: cover property (under_ev);
    full_c: cover property (!f_ready && req && wb_i.we);
endmodule : tdho_top

/* tdho_pkg.sv */
// package of constants and types for the data-link transmit option block
package tdho_pkg;

    // ------------------------------------------------------------
    // register map and bus widths
    // ------------------------------------------------------------
    localparam int         WB_DW      = 32;
    localparam int         WB_AW      = 8;
    localparam logic [7:0] ADR_CTRL   = 8'h00; // link_control_three
    localparam logic [7:0] ADR_COUNT  = 8'h04; // transmit_message_count
    localparam logic [7:0] ADR_DATA   = 8'h08; // outbound octet push
    localparam logic [7:0] ADR_STATUS = 8'h0c; // status, write one to clear
    localparam logic [7:0] ADR_CMD    = 8'h10; // start and stop commands

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         CMD_GO     = 0;
    localparam int         CMD_STOP   = 1;
    localparam int         STA_BUSY   = 0;
    localparam int         STA_DONE   = 1;
    localparam int         STA_UNDER  = 2;
    localparam int         STA_FULL   = 3;
    localparam int         STA_EMPTY  = 4;
    localparam int         CNT_W      = 7;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [6:0] CNT_RESET  = 7'h00;

    // ------------------------------------------------------------
    // line coding constants
    // ------------------------------------------------------------
    localparam logic [7:0]  FLAG_OCTET  = 8'h7e;
    localparam logic [7:0]  ABORT_OCTET = 8'hfe; // zero then seven ones
    localparam logic [7:0]  BOS_TAIL    = 8'hff;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'h8408;
    localparam logic [2:0]  ONES_MAX    = 3'h5;
    localparam logic [4:0]  OCTET_BITS  = 5'h08;
    localparam logic [4:0]  WORD_BITS   = 5'h10;
    localparam int          FIFO_W      = 8;
    localparam int          FIFO_DEPTH  = 4;

    // ------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tdho_wb_req_t;

    // packed so that the fields sit at bits 2..0 of the register
    typedef struct packed {
        logic idle_fill;
        logic check_append;
        logic signalling_select;
    } tdho_ctrl_t;

    typedef enum {TX_FLAG, TX_DATA, TX_FCS, TX_BOS} tdho_tx_state_t;

endpackage : tdho_pkg

/* tdho_remote_model.sv */
// remote terminal model: paces line slots and unpacks received frames
`timescale 1ns/1ns
module tdho_remote_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       slow_i,
    input  wire logic       line_i,
    output logic            slot_o,
    output int              flags_o,
    output int              frames_o,
    output int              hits_o,
    output int              len_o,
    output logic [7:0]      frame_o [0:15]
);
    import tdho_pkg::*;
    localparam logic [15:0] BOS_WORD = {BOS_TAIL, 8'h3c};
    logic [2:0]  div;
    logic        take;
    logic [15:0] raw;
    logic [7:0]  oct;
    logic [7:0]  acc [0:15];
    int          ones;
    int          nb;
    int          nbyte;

    // ------------------------------------------------------------
    // slot pacing, destuffing, flag and frame recovery
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div = 3'h0;
            take = 1'b0;
            raw = 16'h0000;
            ones = 0;
            nb = 0;
            nbyte = 0;
            slot_o <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                raw = {line_i, raw[15:1]}; // lsb of each octet first
                if (!(line_i == 1'b0 && ones == 5))
                begin
                    oct = {line_i, oct[7:1]};
                    nb++;
                end
                ones = line_i ? ones + 1 : 0;
                if (ones >= 7)
                begin
                    nb = 0; // abort run drops the frame
                    nbyte = 0;
                end
                if (nb == 8)
                begin
                    if (nbyte < 16)
                        acc[nbyte] = oct;
                    nbyte++;
                    nb = 0;
                end
                if (raw[15:8] == FLAG_OCTET)
                begin
                    flags_o++; // idle and closing flags
                    if (nbyte > 1)
                    begin
                        frames_o++;
                        len_o = nbyte - 1; // last octet was the flag
                        frame_o = acc;
                    end
                    nbyte = 0;
                    nb = 0;
                end
                if (raw == BOS_WORD)
                    hits_o++; // one bit-pattern word seen
            end
            slot_o <= (div == 3'h0);
            take = slot_o; // line bit shows the cycle after a slot
            div = (div == 3'h0) ? (slow_i ? 3'h4 : 3'h1) : div - 3'h1;
        end
    end
endmodule : tdho_remote_model

/* tb_tdho_top.sv */
// self-checking testbench for the data-link transmit option block
`timescale 1ns/1ns
module tb_tdho_top;
    import tdho_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    tdho_wb_req_t     wb_i = '0;
    logic [WB_DW-1:0] wb_dat_o;
    logic             wb_ack_o;
    logic             dl_slot_i;
    logic             tx_bit_o;
    logic             done_o;
    logic             slow = 1'b0;
    logic [31:0]      rd;
    logic [15:0]      crc = CRC_INIT;
    logic [7:0]       sent [$];
    logic [7:0]       fbytes [0:15];
    int               n_fail = 0;
    int               cmp_count = 0;
    int               n_done = 0;
    int               flags, frames, hits, flen, f0, h0;

    always #5 clk_i = ~clk_i;

    tdho_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dl_slot_i(dl_slot_i),
        .tx_bit_o(tx_bit_o), .transmit_transfer_done_o(done_o));
    tdho_remote_model i_far (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .line_i(tx_bit_o), .slot_o(dl_slot_i), .flags_o(flags),
        .frames_o(frames), .hits_o(hits), .len_o(flen), .frame_o(fbytes));

    // done pulses seen on the line side
    always @(posedge clk_i)
        if (done_o === 1'b1)
            n_done <= n_done + 1;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int k;
        wb_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 3000);
        rd = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_i);
        if (k >= 3000)
        begin
            check(0, 1, "bus ack timeout");
            close_out();
        end
    endtask : wb

    // push one octet and fold it into the expected check word
    task automatic push(input logic [7:0] b);
        wb(1'b1, ADR_DATA, {24'h0, b});
        sent.push_back(b);
        for (int i = 0; i < 8; i++)
            crc = (crc[0] ^ b[i]) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    endtask : push

    task automatic wait_frames(input int n);
        int k;
        for (k = 0; k < 20000 && frames < n; k++)
            @(posedge clk_i);
        if (frames < n)
        begin
            check(0, 1, "frame timeout");
            close_out();
        end
    endtask : wait_frames

    // compare the last received frame with what was pushed
    task automatic check_frame(input logic fcs);
        if (fcs)
        begin
            sent.push_back(~crc[7:0]);
            sent.push_back(~crc[15:8]);
        end
        check(flen, sent.size(), "frame length");
        for (int i = 0; i < sent.size(); i++)
            check({24'h0, fbytes[i]}, {24'h0, sent[i]}, "frame octet");
        sent.delete();
        crc = CRC_INIT;
    endtask : check_frame

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, ADR_CTRL, 0);
        check(rd[2:0], CTRL_RESET, "ctrl reset");
        wb(1'b0, ADR_COUNT, 0);
        check(rd[6:0], CNT_RESET, "count reset");
        wb(1'b0, 8'h40, 0);
        check(rd, 0, "unmapped read");
        repeat (300) @(posedge clk_i);
        check(flags > 10 && frames == 0, 1, "idle flags");
        // message frame with check octets, stuffing exercised
        f0 = frames;
        wb(1'b1, ADR_COUNT, 3);
        push(8'h03);
        push(8'h01);
        push(8'h7f);
        wb(1'b1, ADR_CTRL, 3);
        wb(1'b1, ADR_CMD, 1);
        wait_frames(f0 + 1);
        check_frame(1'b1);
        // slow line, fifo filled to refusal, no check octets
        slow <= 1'b1;
        wb(1'b1, ADR_COUNT, 6);
        for (int i = 0; i < 4; i++)
            push(8'(8'h11 * i));
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_FULL], 1'b1, "fifo full");
        wb(1'b1, ADR_CTRL, 1);
        wb(1'b1, ADR_CMD, 1);
        push(8'hff);
        push(8'h00);
        wait_frames(f0 + 2);
        check_frame(1'b0);
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_EMPTY], 1'b1, "fifo empty");
        // idle fill holds back a pending message frame
        slow <= 1'b0;
        wb(1'b1, ADR_COUNT, 2);
        push(8'h5a);
        push(8'ha5);
        wb(1'b1, ADR_CTRL, 5);
        wb(1'b1, ADR_CMD, 1);
        f0 = flags;
        repeat (400) @(posedge clk_i);
        check(frames, 2, "frame under idle");
        check(flags > f0 + 10, 1, "flags under idle");
        wb(1'b1, ADR_CTRL, 1);
        wait_frames(3);
        check_frame(1'b0);
        // fifo runs dry inside a frame: abort and underrun flag
        wb(1'b1, ADR_CTRL, 1);
        wb(1'b1, ADR_COUNT, 4);
        push(8'h81);
        wb(1'b1, ADR_CMD, 1);
        repeat (200) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_UNDER], 1'b1, "underrun flag");
        check(frames, 3, "aborted frame dropped");
        // bit pattern ignores idle fill and check append
        h0 = hits;
        f0 = n_done;
        wb(1'b1, ADR_CTRL, 6);
        wb(1'b1, ADR_COUNT, 3);
        push(8'h3c);
        wb(1'b1, ADR_CMD, 1);
        for (int k = 0; k < 20000 && n_done == f0; k++)
            @(posedge clk_i);
        if (n_done == f0)
        begin
            check(0, 1, "done timeout");
            close_out();
        end
        repeat (60) @(posedge clk_i);
        check(hits - h0, 3, "pattern repeats");
        check(n_done - f0, 1, "done pulse");
        check(frames, 3, "no frame in pattern");
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_DONE], 1'b1, "done sticky");
        wb(1'b1, ADR_STATUS, 32'h2);
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_DONE], 1'b0, "done cleared");
        // count zero repeats the pattern until a stop, with no done
        h0 = hits;
        f0 = n_done;
        wb(1'b1, ADR_COUNT, 0);
        wb(1'b1, ADR_CTRL, 0);
        push(8'h3c);
        wb(1'b1, ADR_CMD, 1);
        repeat (400) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_BUSY], 1'b1, "busy in endless pattern");
        wb(1'b1, ADR_CMD, 2);
        repeat (100) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 0);
        check(rd[STA_BUSY], 1'b0, "stop ends pattern");
        check(hits - h0 > 8, 1, "endless repeats");
        check(n_done - f0, 0, "no done when endless");
        sent.delete();
        close_out();
    end
endmodule : tb_tdho_top
